/* pll_base_clock_select.sv */
// PLL control and base clock source selector
`timescale 1ns/1ps
module pll_base_clock_select (
	// Clock and reset
	input  wire logic                            REF_CLK,
	input  wire logic                            RST_N,
	// Register port
	input  wire logic [clkgen_pkg::ADDR_W-1:0]   ADDR,
	input  wire logic [clkgen_pkg::DATA_W-1:0]   WDATA,
	input  wire logic                            WR,
	input  wire logic                            RD,
	output logic      [clkgen_pkg::DATA_W-1:0]   RDATA,
	// Clock sources and lock indicator
	input  wire logic                            OSC_REF_CLOCK,
	input  wire logic                            VCO_CLOCK,
	input  wire logic                            LOCK_IN,
	// Outputs
	output logic                                 VCO_ENABLE,
	output logic                                 BASE_CLOCK_OUT,
	output logic                                 IRQ
);

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	clkgen_pkg::state_t   q;
	clkgen_pkg::state_t   d;
	clkgen_pkg::bus_req_t req;
	logic                 osc_rise;
	logic                 vco_rise;
	logic                 src_rise;
	logic                 lock_tgl;
	logic                 rd_ctl;
	logic                 wr_ctl;
	logic                 ev_switch;

	assign req = '{addr: ADDR, wdata: WDATA, wr: WR, rd: RD};

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		d         = q;
		ev_switch = 1'b0;

		// Two-stage synchronisers for pins
		d.sync1 = '{lock: LOCK_IN, vco: VCO_CLOCK, osc: OSC_REF_CLOCK};
		d.sync2 = q.sync1;
		d.prev  = q.sync2;

		osc_rise = q.sync2.osc & ~q.prev.osc;
		vco_rise = q.sync2.vco & ~q.prev.vco;
		src_rise = q.active ? vco_rise : osc_rise;
		lock_tgl = q.sync2.lock ^ q.prev.lock;

		rd_ctl = req.rd && (req.addr == clkgen_pkg::ADDR_LOOP_CTRL);
		wr_ctl = req.wr && (req.addr == clkgen_pkg::ADDR_LOOP_CTRL);

		// Lock-change flag: set beats the read clear
		if (rd_ctl) begin
			d.flag = 1'b0;
		end
		if (lock_tgl) begin
			d.flag = 1'b1;
		end

		// Loop control writes
		if (wr_ctl) begin
			if (q.auto_bw) begin
				d.irq_en = req.wdata[clkgen_pkg::BIT_IRQ_EN];
			end
			if (req.wdata[clkgen_pkg::BIT_PWR] || !q.sel) begin
				d.pwr = req.wdata[clkgen_pkg::BIT_PWR];
			end
			if (!req.wdata[clkgen_pkg::BIT_SEL] || q.pwr) begin
				d.sel = req.wdata[clkgen_pkg::BIT_SEL];
			end
		end

		// Bandwidth control writes
		if (req.wr && (req.addr == clkgen_pkg::ADDR_BW_CTRL)) begin
			d.auto_bw = req.wdata[clkgen_pkg::BIT_AUTO];
		end

		// Event mask writes
		if (req.wr && (req.addr == clkgen_pkg::ADDR_EV_MASK)) begin
			d.ev_mask = req.wdata[clkgen_pkg::EV_N-1:0];
		end

		// VCO clock follows loop power
		d.vco_en = d.pwr;

		// Source selector
		case (q.st)
			clkgen_pkg::ST_RUN: begin
				if (q.sel != q.active) begin
					d.st      = clkgen_pkg::ST_SWITCH;
					d.osc_cnt = '0;
					d.vco_cnt = '0;
				end else if (src_rise) begin
					d.base_out = ~q.base_out;
				end
			end
			clkgen_pkg::ST_SWITCH: begin
				// Output held until both clocks have been seen three times
				if (osc_rise && q.osc_cnt != clkgen_pkg::SWITCH_EDGES) begin
					d.osc_cnt = q.osc_cnt + 2'h1;
				end
				if (vco_rise && q.vco_cnt != clkgen_pkg::SWITCH_EDGES) begin
					d.vco_cnt = q.vco_cnt + 2'h1;
				end
				if (q.osc_cnt == clkgen_pkg::SWITCH_EDGES &&
				    q.vco_cnt == clkgen_pkg::SWITCH_EDGES) begin
					d.active  = q.sel;
					d.st      = clkgen_pkg::ST_RUN;
					ev_switch = 1'b1;
				end
			end
			default: begin
				d.st = clkgen_pkg::ST_RUN;
			end
		endcase

		// Sticky events: write one clears, a new event wins
		if (req.wr && (req.addr == clkgen_pkg::ADDR_EV_STAT)) begin
			d.ev_stat = q.ev_stat & ~req.wdata[clkgen_pkg::EV_N-1:0];
		end
		if (lock_tgl) begin
			d.ev_stat[clkgen_pkg::EV_LOCK] = 1'b1;
		end
		if (ev_switch) begin
			d.ev_stat[clkgen_pkg::EV_SWITCH] = 1'b1;
		end

		// Interrupt line
		d.irq = (d.flag & d.irq_en & d.auto_bw)
		      | (|(d.ev_stat & d.ev_mask));

		// Read data, valid the cycle after the strobe
		d.rdata = '0;
		if (req.rd) begin
			if (req.addr == clkgen_pkg::ADDR_LOOP_CTRL) begin
				d.rdata[clkgen_pkg::BIT_IRQ_EN] = q.irq_en & q.auto_bw;
				d.rdata[clkgen_pkg::BIT_FLAG]   = q.flag & q.auto_bw;
				d.rdata[clkgen_pkg::BIT_PWR]    = q.pwr;
				d.rdata[clkgen_pkg::BIT_SEL]    = q.sel;
			end else if (req.addr == clkgen_pkg::ADDR_BW_CTRL) begin
				d.rdata[clkgen_pkg::BIT_AUTO] = q.auto_bw;
				d.rdata[clkgen_pkg::BIT_LOCK] = q.sync2.lock;
			end else if (req.addr == clkgen_pkg::ADDR_EV_STAT) begin
				d.rdata[clkgen_pkg::EV_N-1:0] = q.ev_stat;
			end else if (req.addr == clkgen_pkg::ADDR_EV_MASK) begin
				d.rdata[clkgen_pkg::EV_N-1:0] = q.ev_mask;
			end else begin
				d.rdata = '0;
			end
		end
	end

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			q          <= '0;
			q.st       <= clkgen_pkg::ST_RUN;
			q.flag     <= 1'b0;
			q.irq_en   <= 1'b0;
			q.pwr      <= clkgen_pkg::RST_PWR;
			q.vco_en   <= clkgen_pkg::RST_PWR;
			q.sel      <= clkgen_pkg::RST_SEL;
			q.active   <= clkgen_pkg::RST_SEL;
			q.auto_bw  <= clkgen_pkg::RST_AUTO;
		end else begin
			q <= d;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign RDATA          = q.rdata;
	assign VCO_ENABLE     = q.vco_en;
	assign BASE_CLOCK_OUT = q.base_out;
	assign IRQ            = q.irq;

endmodule

/* clkgen_pkg.sv */
// Constants, types and register map of the PLL base clock selector
//
// Contract
// - A change of the lock indicator in either direction sets the lock-change flag.
// - The interrupt is requested while the lock-change flag and lock irq enable are both set; the logic also gates it with automatic bandwidth mode.
// - With automatic bandwidth mode clear, the lock-change flag reads as zero.
// - Any read of the loop control register clears the lock-change flag; the logic lets a lock change in the same cycle set it instead.
// - Reset clears the lock-change flag.
// - Loop power-on at one runs the PLL and enables the VCO clock, at zero it is off.
// - A write clearing loop power-on is ignored while the VCO clock is selected.
// - Reset sets loop power-on so the loop settles during power-up.
// - The base clock output is half the selected source, one selecting VCO, zero oscillator.
// - A write setting the source select is ignored while loop power-on is clear.
// - A source switch completes within three oscillator and three VCO clock cycles.
// - During a source switch the base clock output holds still.
// - Reset clears the source select so the oscillator drives the base clock.
// - With automatic bandwidth mode clear, lock irq enable cannot be written and reads zero.
// - Reset clears lock irq enable; one enables and zero disables lock interrupts.
package clkgen_pkg;

	// ------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------
	localparam int         ADDR_W         = 4;
	localparam int         DATA_W         = 8;
	localparam logic [3:0] ADDR_LOOP_CTRL = 4'h0;
	localparam logic [3:0] ADDR_BW_CTRL   = 4'h1;
	localparam logic [3:0] ADDR_EV_STAT   = 4'h2;
	localparam logic [3:0] ADDR_EV_MASK   = 4'h3;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int BIT_IRQ_EN = 7;
	localparam int BIT_FLAG   = 6;
	localparam int BIT_PWR    = 5;
	localparam int BIT_SEL    = 4;
	localparam int BIT_AUTO   = 7;
	localparam int BIT_LOCK   = 6;
	localparam int EV_LOCK    = 0;
	localparam int EV_SWITCH  = 1;
	localparam int EV_N       = 2;

	// ------------------------------------------------------------
	// Reset values and timing
	// ------------------------------------------------------------
	localparam logic       RST_PWR     = 1'b1;
	localparam logic       RST_SEL     = 1'b0;
	localparam logic       RST_AUTO    = 1'b0;
	localparam logic [1:0] SWITCH_EDGES = 2'h3;

	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		ST_RUN    = 2'b01,
		ST_SWITCH = 2'b10
	} sel_state_t;

	typedef struct packed {
		logic lock;
		logic vco;
		logic osc;
	} pins_t;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic              wr;
		logic              rd;
	} bus_req_t;

	typedef struct packed {
		sel_state_t        st;
		pins_t             sync1;
		pins_t             sync2;
		pins_t             prev;
		logic              irq_en;
		logic              flag;
		logic              pwr;
		logic              sel;
		logic              active;
		logic              auto_bw;
		logic [1:0]        osc_cnt;
		logic [1:0]        vco_cnt;
		logic              base_out;
		logic              vco_en;
		logic              irq;
		logic [EV_N-1:0]   ev_stat;
		logic [EV_N-1:0]   ev_mask;
		logic [DATA_W-1:0] rdata;
	} state_t;

endpackage

/* pll_checker.sv */
// Port checker of the PLL base clock selector
`timescale 1ns/1ps
module pll_checker (
	// Clock and reset
	input wire logic                          REF_CLK,
	input wire logic                          RST_N,
	// Register port
	input wire logic [clkgen_pkg::ADDR_W-1:0] ADDR,
	input wire logic [clkgen_pkg::DATA_W-1:0] WDATA,
	input wire logic                          WR,
	input wire logic                          RD,
	input wire logic [clkgen_pkg::DATA_W-1:0] RDATA,
	// Sources and outputs
	input wire logic                          OSC_REF_CLOCK,
	input wire logic                          VCO_CLOCK,
	input wire logic                          LOCK_IN,
	input wire logic                          VCO_ENABLE,
	input wire logic                          BASE_CLOCK_OUT,
	input wire logic                          IRQ
);
	// ----------------
	// Properties
	// ----------------
	default clocking @(posedge REF_CLK); endclocking
	default disable iff (!RST_N);
	a_rst_clk: assert property ($rose(RST_N) |-> VCO_ENABLE && !BASE_CLOCK_OUT)
		else $error("clock outputs wrong after reset");
	a_rst_irq: assert property ($rose(RST_N) |-> !IRQ && RDATA == 8'h00)
		else $error("irq or read data wrong after reset");
	a_pwr_on: assert property (WR && ADDR == 4'h0 && WDATA[5] |-> ##[1:3] VCO_ENABLE)
		else $error("vco enable missing after power on");
	a_flag_clear: assert property ($stable(LOCK_IN)[*6] ##0 (RD && ADDR == 4'h0) ##1 $stable(LOCK_IN) ##1 (RD && ADDR == 4'h0 && $stable(LOCK_IN)) |=> !RDATA[6])
		else $error("flag survived a read");
	a_out_rate: assert property ($changed(BASE_CLOCK_OUT) |=> $stable(BASE_CLOCK_OUT))
		else $error("base clock toggled too fast");
	a_flag_hidden: assert property (RD && ADDR == 4'h1 ##1 !RDATA[7] ##1 RD && ADDR == 4'h0 |=> !RDATA[6] && !RDATA[7])
		else $error("hidden bits read as one");
	a_pwr_kept: assert property (RD && ADDR == 4'h0 ##1 RDATA[4] ##1 WR && ADDR == 4'h0 && !WDATA[5] |=> VCO_ENABLE[*3])
		else $error("power cleared while vco selected");
	a_sel_refused: assert property (RD && ADDR == 4'h0 ##1 !RDATA[5] ##1 WR && ADDR == 4'h0 && WDATA[4] ##2 RD && ADDR == 4'h0 |=> !RDATA[4])
		else $error("select set while power off");
endmodule
bind pll_base_clock_select pll_checker i_chk (.REF_CLK, .RST_N, .ADDR,
	.WDATA, .WR, .RD, .RDATA, .OSC_REF_CLOCK, .VCO_CLOCK, .LOCK_IN,
	.VCO_ENABLE, .BASE_CLOCK_OUT, .IRQ);

/* tb_top.sv */
// Self-checking bench of the PLL base clock selector
`timescale 1ns/1ps
module tb_top;
	logic       REF_CLK = 1'b0;
	logic       RST_N = 1'b0;
	logic [3:0] ADDR = 4'h0;
	logic [7:0] WDATA = 8'h00;
	logic       WR = 1'b0;
	logic       RD = 1'b0;
	logic       OSC_REF_CLOCK = 1'b0;
	logic       VCO_CLOCK = 1'b0;
	logic       LOCK_IN = 1'b0;
	logic [7:0] RDATA;
	logic       VCO_ENABLE;
	logic       BASE_CLOCK_OUT;
	logic       IRQ;
	int         err_total = 0;
	int         n_tests = 0;
	int         cnt = 0;
	pll_base_clock_select i_dut (.REF_CLK, .RST_N, .ADDR, .WDATA, .WR,
		.RD, .RDATA, .OSC_REF_CLOCK, .VCO_CLOCK, .LOCK_IN, .VCO_ENABLE,
		.BASE_CLOCK_OUT, .IRQ);
	// ----------------
	// Clocks, oscillator 8 cycles, VCO 6 cycles
	// ----------------
	initial begin
		forever #12.5 REF_CLK = ~REF_CLK;
	end
	always @(posedge REF_CLK) begin
		cnt <= cnt + 1;
		if (cnt % 4 == 3)
			OSC_REF_CLOCK <= ~OSC_REF_CLOCK;
		if (cnt % 3 == 2)
			VCO_CLOCK <= ~VCO_CLOCK;
	end
	// ----------------
	// Tasks
	// ----------------
	task chk(input string s, input logic [7:0] e, input logic [7:0] g);
		n_tests++;
		if (g !== e) begin
			err_total++;
			$display("Error %s expected %h seen %h", s, e, g);
		end
	endtask
	task idle(input int n);
		repeat (n) @(posedge REF_CLK);
		#1;
	endtask
	task wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge REF_CLK);
		WR <= 1'b1;
		ADDR <= a;
		WDATA <= d;
		@(posedge REF_CLK);
		WR <= 1'b0;
	endtask
	task rd(input logic [3:0] a, input logic [7:0] e, input string s);
		@(posedge REF_CLK);
		RD <= 1'b1;
		ADDR <= a;
		@(posedge REF_CLK);
		RD <= 1'b0;
		#1;
		if (s != "")
			chk(s, e, RDATA);
	endtask
	task lk;
		@(posedge REF_CLK);
		LOCK_IN <= ~LOCK_IN;
		idle(8);
	endtask
	task edge_gap(output int n);
		logic b;
		#1;
		n = 0;
		b = BASE_CLOCK_OUT;
		while (BASE_CLOCK_OUT === b && n < 99) begin
			idle(1);
			n++;
		end
	endtask
	// ----------------
	// Scenarios
	// ----------------
	task t_reset;
		int n;
		rd(4'h0, 8'h20, "ctrl_rst");
		chk("vco_en", 8'h01, 8'(VCO_ENABLE));
		edge_gap(n);
		edge_gap(n);
		chk("osc_gap", 8'h08, 8'(n));
		wr(4'h9, 8'hFF);
		rd(4'h9, 8'h00, "unmapped");
		rd(4'h0, 8'h20, "ctrl_keep");
	endtask
	task t_events;
		lk;
		chk("irq_ev", 8'h00, 8'(IRQ));
		rd(4'h2, 8'h01, "ev_stat");
		rd(4'h0, 8'h20, "flag_hid");
		wr(4'h2, 8'h01);
		idle(2);
		chk("irq_clr", 8'h00, 8'(IRQ));
		wr(4'h3, 8'h03);
		wr(4'h0, 8'hA0);
		lk;
		chk("irq_mask", 8'h01, 8'(IRQ));
		rd(4'h1, 8'h00, "bw");
		rd(4'h0, 8'h20, "ie_blk");
		wr(4'h3, 8'h00);
		wr(4'h2, 8'h03);
	endtask
	task t_lock;
		wr(4'h1, 8'h80);
		rd(4'h0, 8'h00, "");
		wr(4'h0, 8'hA0);
		lk;
		chk("irq_flag", 8'h01, 8'(IRQ));
		rd(4'h0, 8'hE0, "flag_set");
		rd(4'h0, 8'hA0, "flag_clr");
		chk("irq_off", 8'h00, 8'(IRQ));
		lk;
		rd(4'h0, 8'hE0, "flag_fall");
		wr(4'h0, 8'h20);
		rd(4'h0, 8'h20, "ie_off");
		wr(4'h2, 8'h03);
	endtask
	task t_switch;
		int n;
		wr(4'h0, 8'h30);
		edge_gap(n);
		chk("sw_time", 8'h01, 8'(n <= 60));
		edge_gap(n);
		edge_gap(n);
		chk("vco_gap", 8'h06, 8'(n));
		rd(4'h0, 8'h30, "sel_on");
		wr(4'h0, 8'h10);
		rd(4'h0, 8'h30, "pwr_kept");
		chk("vco_kept", 8'h01, 8'(VCO_ENABLE));
		wr(4'h0, 8'h20);
		edge_gap(n);
		edge_gap(n);
		edge_gap(n);
		chk("osc_back", 8'h08, 8'(n));
		wr(4'h0, 8'h00);
		rd(4'h0, 8'h00, "pwr_off");
		chk("vco_off", 8'h00, 8'(VCO_ENABLE));
		wr(4'h0, 8'h10);
		rd(4'h0, 8'h00, "sel_blk");
	endtask
	task final_report;
		if (err_total == 0 && n_tests > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	initial begin
		repeat (16) @(posedge REF_CLK);
		RST_N <= 1'b1;
		t_reset;
		t_events;
		t_lock;
		t_switch;
		final_report;
	end
	initial begin
		#100000;
		err_total++;
		final_report;
	end
endmodule
